// >>> fsc_defs.svh
/*
  constants for the synthesizer control register bank: control codes,
  field positions, reset values and counts.
  assumes inclusion by bare name from each design file.
*/
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

// ************************************************
// control codes in word bits 2:0
// ************************************************
`define FSC_CODE_INT_FRACTIONAL_VALUE 3'h0
`define FSC_CODE_PHASE 3'h1
`define FSC_CODE_MOD_REF 3'h2
`define FSC_CODE_FUNCTION 3'h3
`define FSC_CODE_TIMEOUT 3'h4

// ************************************************
// field positions
// ************************************************
`define FSC_CTRL_MSB 2
`define FSC_WORD_LSB 3
`define FSC_FRACTIONAL_VALUE_MSB 14
`define FSC_INT_LSB 15
`define FSC_INT_MSB 26
`define FSC_MUX_LSB 27
`define FSC_MUX_MSB 30
`define FSC_PHASE_MSB 14
`define FSC_MOD_MSB 14
`define FSC_RCNT_LSB 15
`define FSC_RCNT_MSB 19
`define FSC_DOUBLER_BIT 20
`define FSC_HALFDIV_BIT 21
`define FSC_PRESCALER_BIT 22
`define FSC_CPI_LSB 24
`define FSC_CPI_MSB 27
`define FSC_CSR_BIT 28
`define FSC_NOISE_LSB 29
`define FSC_NOISE_MSB 30
`define FSC_CNT_RESET_BIT 3
`define FSC_CP_TRISTATE_BIT 4
`define FSC_POWER_DOWN_BIT 5
`define FSC_POLARITY_BIT 6
`define FSC_LOCK_PREC_BIT 7
`define FSC_SD_NORESET_BIT 14
`define FSC_CLKDIV_LSB 7
`define FSC_CLKDIV_MSB 18
`define FSC_DIVMODE_LSB 19
`define FSC_DIVMODE_MSB 20

// ************************************************
// encodings, reset values, counts
// ************************************************
`define FSC_NOISE_LOWEST_SPUR 2'h3
`define FSC_NOISE_LOWEST_NOISE 2'h0
`define FSC_DIVMODE_FAST_LOCK 2'h1
`define FSC_DIVMODE_RESYNC 2'h2
`define FSC_DIVMODE_OFF 2'h0
`define FSC_WORD_RESET 32'h00000000
`define FSC_LOCK_CYCLES 6'h28
`define FSC_RDIV_FULL 6'h20

`endif

// >>> fsc_pkg.sv
/*
  types shared by the synthesizer control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package fsc_pkg;
  typedef enum logic [1:0] {
    timeout_idle,
    timeout_fast_lock,
    timeout_resync
  } fsc_timeout_state_type;
endpackage

// >>> fsc_ref_divider.sv
/*
  reference path: doubler edge select, 6-bit reference counter and
  optional divide-by-two toggle, giving the detector reference.
  assumes ref_level is already synchronised to ref_clk.
*/
`timescale 1ns/10ps
`include "fsc_defs.svh"

module fsc_ref_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // reference and control
  input wire logic ref_level,
  input wire logic hold,
  input wire logic doubler,
  input wire logic half_divide,
  input wire logic [4:0] ratio_code,
  // detector reference
  output logic pfd_pulse,
  output logic pfd_level
);
  logic ref_last;
  logic [5:0] count;
  logic [5:0] ratio;
  logic active_edge;
  logic wrap;
  logic toggle;

  // code 0 gives the full ratio of 32
  assign ratio = (ratio_code == 5'h00) ? `FSC_RDIV_FULL : {1'b0, ratio_code};
  // both edges with doubler, falling edge only without
  assign active_edge = doubler ? (ref_level ^ ref_last) : (ref_last & ~ref_level);
  // a ratio cut below the running count wraps on the next active edge instead of rolling over
  assign wrap = active_edge && (count >= ratio - 6'h01);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ref_last <= 1'b0;
    end else begin
      ref_last <= ref_level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || hold) begin
      count <= 6'h00;
    end else if (wrap) begin
      count <= 6'h00;
    end else if (active_edge) begin
      count <= count + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || hold) begin
      toggle <= 1'b0;
    end else if (wrap) begin
      toggle <= ~toggle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || hold) begin
      pfd_pulse <= 1'b0;
      pfd_level <= 1'b0;
    end else begin
      // toggle stage passes every second wrap, giving a 50% duty level
      pfd_pulse <= half_divide ? (wrap & ~toggle) : wrap;
      pfd_level <= half_divide ? toggle : wrap;
    end
  end
endmodule

// >>> fsc_ctrl.sv
/*
  control register bank of a fractional-n synthesizer: three-wire serial
  word capture, register decode, double buffering, power-down and
  counter control, lock detect and the timeout counter.
  assumes serial pins, reference and phase error flags are asynchronous.
*/
`timescale 1ns/10ps
`include "fsc_defs.svh"

module fsc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // three-wire serial port
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_enable,
  // reference and detector status
  input wire logic reference_input,
  input wire logic phase_err_lt_10ns,
  input wire logic phase_err_lt_6ns,
  // integer/fraction settings
  output logic [11:0] integer_value,
  output logic [11:0] fractional_value,
  output logic [3:0] muxout_select,
  output logic sigma_delta_reset,
  // double buffered settings
  output logic [11:0] phase_word,
  output logic [11:0] fractional_modulus,
  output logic [4:0] reference_count,
  output logic reference_doubler,
  output logic reference_half_divider,
  output logic [3:0] charge_pump_current,
  // direct settings
  output logic dither_enable,
  output logic low_noise_mode,
  output logic cycle_slip_reduction_enable,
  output logic prescaler_8_9,
  output logic detector_polarity,
  output logic lock_precision_select,
  // function control
  output logic counter_reset,
  output logic charge_pump_tristate,
  output logic power_down,
  // detector reference and status
  output logic pfd_reference,
  output logic lock_detect,
  // timeout divider
  output logic [11:0] clock_divider_value,
  output logic fast_lock_active,
  output logic phase_resync_pulse
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  localparam int NUM_PINS = 6;
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;

  assign pin_raw = {phase_err_lt_6ns, phase_err_lt_10ns, reference_input,
                    load_enable, serial_data, serial_clock};

  // two flops per pin; the first is read by the second only
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic sclk_last;
  logic load_last;
  logic sclk_rise;
  logic load_rise;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclk_last <= 1'b0;
      load_last <= 1'b0;
    end else begin
      sclk_last <= pin_sync[0];
      load_last <= pin_sync[2];
    end
  end

  assign sclk_rise = pin_sync[0] & ~sclk_last;
  assign load_rise = pin_sync[2] & ~load_last;

  // ************************************************
  // serial input register
  // ************************************************
  logic [31:0] shift_word;

  // keeps shifting in power-down, so words still latch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_word <= `FSC_WORD_RESET;
    end else if (sclk_rise) begin
      shift_word <= {shift_word[30:0], pin_sync[1]};
    end
  end

  function automatic logic code_hit(input logic [31:0] word, input logic [2:0] code);
    code_hit = (word[`FSC_CTRL_MSB:0] == code);
  endfunction

  logic wr_int;
  logic wr_phase;
  logic wr_modref;
  logic wr_func;
  logic wr_timeout;

  assign wr_int = load_rise && code_hit(shift_word, `FSC_CODE_INT_FRACTIONAL_VALUE);
  assign wr_phase = load_rise && code_hit(shift_word, `FSC_CODE_PHASE);
  assign wr_modref = load_rise && code_hit(shift_word, `FSC_CODE_MOD_REF);
  assign wr_func = load_rise && code_hit(shift_word, `FSC_CODE_FUNCTION);
  assign wr_timeout = load_rise && code_hit(shift_word, `FSC_CODE_TIMEOUT);

  // ************************************************
  // registers
  // ************************************************
  logic [31:0] int_fractional_value_reg;
  logic [31:0] phase_word_reg;
  logic [31:0] modulus_reference_reg;
  logic [31:0] function_control_reg;
  logic [31:0] timeout_divider_reg;
  logic [31:0] phase_active;
  logic [31:0] modref_active;

  // codes 101 to 111 are ignored; contents survive power-down
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_fractional_value_reg <= `FSC_WORD_RESET;
      phase_word_reg <= `FSC_WORD_RESET;
      modulus_reference_reg <= `FSC_WORD_RESET;
      function_control_reg <= `FSC_WORD_RESET;
      timeout_divider_reg <= `FSC_WORD_RESET;
    end else begin
      if (wr_int) int_fractional_value_reg <= shift_word;
      if (wr_phase) phase_word_reg <= shift_word;
      if (wr_modref) modulus_reference_reg <= shift_word;
      if (wr_func) function_control_reg <= shift_word;
      if (wr_timeout) timeout_divider_reg <= shift_word;
    end
  end

  // buffered copies move only on an integer/fraction write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_active <= `FSC_WORD_RESET;
      modref_active <= `FSC_WORD_RESET;
    end else if (wr_int) begin
      phase_active <= phase_word_reg;
      modref_active <= modulus_reference_reg;
    end
  end

  // ************************************************
  // decoded settings
  // ************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sigma_delta_reset <= 1'b0;
    end else begin
      sigma_delta_reset <= wr_int && !function_control_reg[`FSC_SD_NORESET_BIT];
    end
  end

  assign integer_value = int_fractional_value_reg[`FSC_INT_MSB:`FSC_INT_LSB];
  assign fractional_value = int_fractional_value_reg[`FSC_FRACTIONAL_VALUE_MSB:`FSC_WORD_LSB];
  assign muxout_select = int_fractional_value_reg[`FSC_MUX_MSB:`FSC_MUX_LSB];
  assign phase_word = phase_active[`FSC_PHASE_MSB:`FSC_WORD_LSB];
  assign fractional_modulus = modref_active[`FSC_MOD_MSB:`FSC_WORD_LSB];
  assign reference_count = modref_active[`FSC_RCNT_MSB:`FSC_RCNT_LSB];
  assign reference_doubler = modref_active[`FSC_DOUBLER_BIT];
  assign reference_half_divider = modref_active[`FSC_HALFDIV_BIT];
  assign charge_pump_current = modref_active[`FSC_CPI_MSB:`FSC_CPI_LSB];
  assign dither_enable = (modulus_reference_reg[`FSC_NOISE_MSB:`FSC_NOISE_LSB] ==
                          `FSC_NOISE_LOWEST_SPUR);
  assign low_noise_mode = (modulus_reference_reg[`FSC_NOISE_MSB:`FSC_NOISE_LSB] ==
                           `FSC_NOISE_LOWEST_NOISE);
  assign cycle_slip_reduction_enable = modulus_reference_reg[`FSC_CSR_BIT];
  assign prescaler_8_9 = modulus_reference_reg[`FSC_PRESCALER_BIT];
  assign detector_polarity = function_control_reg[`FSC_POLARITY_BIT];
  assign lock_precision_select = function_control_reg[`FSC_LOCK_PREC_BIT];
  assign power_down = function_control_reg[`FSC_POWER_DOWN_BIT];
  assign counter_reset = function_control_reg[`FSC_CNT_RESET_BIT] | power_down;
  assign charge_pump_tristate = function_control_reg[`FSC_CP_TRISTATE_BIT] | power_down;
  assign clock_divider_value = timeout_divider_reg[`FSC_CLKDIV_MSB:`FSC_CLKDIV_LSB];

  // ************************************************
  // reference path
  // ************************************************
  logic pfd_pulse;

  fsc_ref_divider u_ref_divider (
    .ref_clk(ref_clk),
    .reset(reset),
    .ref_level(pin_sync[3]),
    .hold(counter_reset),
    .doubler(reference_doubler),
    .half_divide(reference_half_divider),
    .ratio_code(reference_count),
    .pfd_pulse(pfd_pulse),
    .pfd_level(pfd_reference)
  );

  // ************************************************
  // lock detect
  // ************************************************
  logic [5:0] lock_count;
  logic err_ok;

  assign err_ok = lock_precision_select ? pin_sync[5] : pin_sync[4];

  // flags are sampled once per detector cycle; a miss restarts the run
  always_ff @(posedge ref_clk) begin
    if (reset || power_down) begin
      lock_count <= 6'h00;
      lock_detect <= 1'b0;
    end else if (pfd_pulse) begin
      if (!err_ok) begin
        lock_count <= 6'h00;
        lock_detect <= 1'b0;
      end else if (lock_count == `FSC_LOCK_CYCLES - 6'h01) begin
        lock_detect <= 1'b1;
      end else begin
        lock_count <= lock_count + 6'h01;
      end
    end
  end

  // ************************************************
  // timeout counter
  // ************************************************
  fsc_pkg::fsc_timeout_state_type timeout_state;
  logic [11:0] timeout_count;
  logic [1:0] div_mode;

  assign div_mode = timeout_divider_reg[`FSC_DIVMODE_MSB:`FSC_DIVMODE_LSB];
  assign fast_lock_active = (timeout_state == fsc_pkg::timeout_fast_lock);

  // started by an integer/fraction write, counted in detector cycles
  always_ff @(posedge ref_clk) begin
    if (reset || counter_reset) begin
      timeout_state <= fsc_pkg::timeout_idle;
      timeout_count <= 12'h000;
      phase_resync_pulse <= 1'b0;
    end else begin
      phase_resync_pulse <= 1'b0;
      if (wr_int) begin
        timeout_count <= clock_divider_value;
        unique case (div_mode)
          `FSC_DIVMODE_FAST_LOCK: timeout_state <= fsc_pkg::timeout_fast_lock;
          `FSC_DIVMODE_RESYNC: timeout_state <= fsc_pkg::timeout_resync;
          default: timeout_state <= fsc_pkg::timeout_idle;
        endcase
      end else if (pfd_pulse && timeout_state != fsc_pkg::timeout_idle) begin
        if (timeout_count <= 12'h001) begin
          phase_resync_pulse <= (timeout_state == fsc_pkg::timeout_resync);
          timeout_state <= fsc_pkg::timeout_idle;
        end else begin
          timeout_count <= timeout_count - 12'h001;
        end
      end
    end
  end
endmodule

// >>> fsc_ctrl_assertions.sv
/*
  port checks for the synthesizer control bank.
  assumes one clock, ref_clk, with synchronous active-high reset.
*/
`timescale 1ns/10ps

module fsc_ctrl_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // detector status
  input wire logic phase_err_lt_10ns,
  input wire logic phase_err_lt_6ns,
  // observed outputs
  input wire logic dither_enable,
  input wire logic low_noise_mode,
  input wire logic lock_precision_select,
  input wire logic counter_reset,
  input wire logic charge_pump_tristate,
  input wire logic power_down,
  input wire logic lock_detect,
  input wire logic sigma_delta_reset,
  input wire logic fast_lock_active,
  input wire logic phase_resync_pulse
);
  // ************
  // properties
  // ************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  pd_counter_hold_a: assert property (power_down |-> counter_reset)
    else $error("counters not held in power-down");
  pd_tristate_a: assert property (power_down |-> charge_pump_tristate)
    else $error("charge pump driven in power-down");
  pd_lock_clear_a: assert property (power_down [*3] |-> !lock_detect)
    else $error("lock kept through power-down");
  dither_mode_a: assert property (!(dither_enable && low_noise_mode))
    else $error("dither on in lowest noise mode");
  sd_pulse_a: assert property (sigma_delta_reset |=> !sigma_delta_reset)
    else $error("modulator reset longer than one cycle");
  resync_pulse_a: assert property (phase_resync_pulse |=> !phase_resync_pulse)
    else $error("resync pulse longer than one cycle");
  mode_excl_a: assert property (fast_lock_active |-> !phase_resync_pulse)
    else $error("fast lock and resync together");
  reset_abort_a: assert property (counter_reset [*3] |-> !fast_lock_active)
    else $error("fast lock runs with counters held");
  lock_cause_a: assert property ($rose(lock_detect) |->
    (lock_precision_select ? $past(phase_err_lt_6ns, 4) : $past(phase_err_lt_10ns, 4)))
    else $error("lock set without small phase error");
endmodule

bind fsc_ctrl fsc_ctrl_assertions u_fsc_ctrl_assertions (.*);

// >>> fsc_host_model.sv
/*
  host side of the three-wire serial port: shifts words in msb first.
  assumes calls to send start after reset release, from a clock edge.
*/
`timescale 1ns/10ps

module fsc_host_model (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic serial_clock,
  output logic serial_data,
  output logic load_enable
);
  // ************
  // word sender
  // ************
  initial begin
    serial_clock = 1'h0;
    serial_data = 1'h1;
    load_enable = 1'h0;
  end

  // four cycles a phase, one more than the synchronisers need
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serial_data <= w[i];
      repeat (4) @(posedge ref_clk);
      serial_clock <= 1'h1;
      repeat (4) @(posedge ref_clk);
      serial_clock <= 1'h0;
    end
    // no pull on the data pin: show the inverse once released
    serial_data <= ~w[0];
    repeat (4) @(posedge ref_clk);
    load_enable <= 1'h1;
    repeat (4) @(posedge ref_clk);
    load_enable <= 1'h0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// >>> fsc_ctrl_tb.sv
/*
  self-checking bench for the synthesizer control bank.
  assumes the host model drives the serial pins and the checker is bound.
*/
`timescale 1ns/10ps

module fsc_ctrl_tb;
  // ************
  // signals
  // ************
  logic ref_clk, serial_clock, serial_data, load_enable;
  logic reset = 1'h1;
  logic reference_input = 1'h0;
  logic phase_err_lt_10ns = 1'h0;
  logic phase_err_lt_6ns = 1'h0;
  logic [11:0] integer_value, fractional_value, phase_word, fractional_modulus;
  logic [11:0] clock_divider_value;
  logic [4:0] reference_count;
  logic [3:0] muxout_select, charge_pump_current;
  logic sigma_delta_reset, reference_doubler, reference_half_divider, dither_enable;
  logic low_noise_mode, cycle_slip_reduction_enable, prescaler_8_9, detector_polarity;
  logic lock_precision_select, counter_reset, charge_pump_tristate, power_down;
  logic pfd_reference, lock_detect, fast_lock_active, phase_resync_pulse;
  int n_errors = 0, comparisons = 0, sd_n = 0, rs_n = 0, fl_n = 0, div = 0, p, q;
  logic [4:0] rt[5] = '{5'h02, 5'h00, 5'h03, 5'h02, 5'h01};
  logic [3:0] ft[5] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h0};
  int pt[5] = '{20, 320, 15, 40, 10};
  logic [4:0] ut[5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  logic [4:0] et[5] = '{5'h10, 5'h08, 5'h1C, 5'h02, 5'h01};
  // int 200 keeps above the 8/9 prescaler minimum
  logic [31:0] int_word = {1'h0, 4'h5, 12'h0C8, 12'h011, 3'h0};
  wire [4:0] fn_bits = {counter_reset, charge_pump_tristate, power_down,
    detector_polarity, lock_precision_select};

  fsc_ctrl DUT (.*);
  fsc_host_model host (.*);

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // reference toggles every 5 cycles; event counters sampled before updates
  always @(posedge ref_clk) begin
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4) reference_input <= ~reference_input;
    if (sigma_delta_reset === 1'h1) sd_n <= sd_n + 1;
    if (phase_resync_pulse === 1'h1) rs_n <= rs_n + 1;
    if (fast_lock_active === 1'h1) fl_n <= fl_n + 1;
  end

  // ************
  // helpers
  // ************
  function automatic logic [31:0] mr(logic [1:0] nz, logic [3:0] f, logic [3:0] c,
      logic [4:0] r);
    return {1'h0, nz, f[3], c, 1'h0, f[2:0], r, 12'hABC, 3'h2};
  endfunction

  function automatic logic [31:0] fw(logic b14, logic [4:0] u);
    return {17'h0, b14, 6'h0, u, 3'h3};
  endfunction

  function automatic logic [31:0] tw(logic [1:0] md, logic [11:0] v);
    return {11'h0, md, v, 4'h0, 3'h4};
  endfunction

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic await(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) begin
      @(negedge ref_clk);
      p++;
    end
    // back on the rising edge, so later stimulus keeps to it
    @(posedge ref_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end

  // ************
  // tests
  // ************
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (4) @(posedge ref_clk);
    check("low_noise_mode", low_noise_mode, 1'h1);
    $display("reset test done");
    host.send(tw(2'h0, 12'h000));
    host.send(fw(1'h0, 5'h08));
    host.send(mr(2'h3, 4'h4, 4'hA, 5'h01));
    host.send({17'h0, 12'h123, 3'h1});
    check("phase_word", phase_word, 12'h000);
    check("fractional_modulus", fractional_modulus, 12'h000);
    check("dither_enable", dither_enable, 1'h1);
    check("low_noise_mode", low_noise_mode, 1'h0);
    check("prescaler_8_9", prescaler_8_9, 1'h1);
    host.send(int_word);
    check("phase_word", phase_word, 12'h123);
    check("fractional_modulus", fractional_modulus, 12'hABC);
    check("reference_count", reference_count, 5'h01);
    check("charge_pump_current", charge_pump_current, 4'hA);
    check("int_fractional_value", {muxout_select, integer_value, fractional_value}, 28'h50C8011);
    check("sd_reset_count", sd_n, 1);
    for (int c = 5; c < 8; c++) begin
      host.send({17'h0, 12'h7FF, c[2:0]});
    end
    host.send(int_word);
    check("phase_word", phase_word, 12'h123);
    check("power_down", power_down, 1'h0);
    host.send(mr(2'h0, 4'h8, 4'h0, 5'h01));
    check("dither_enable", dither_enable, 1'h0);
    check("low_noise_mode", low_noise_mode, 1'h1);
    check("cycle_slip", cycle_slip_reduction_enable, 1'h1);
    $display("decode test done");
    for (int i = 0; i < 5; i++) begin
      host.send(mr(2'h0, ft[i], 4'h0, rt[i]));
      host.send(int_word);
      check("ref_select", {reference_half_divider, reference_doubler}, ft[i][1:0]);
      p = 0;
      await(pfd_reference, 1'h0, 2000);
      await(pfd_reference, 1'h1, 2000);
      p = 0;
      await(pfd_reference, 1'h0, 2000);
      await(pfd_reference, 1'h1, 2000);
      check("pfd_period", p, pt[i]);
    end
    $display("reference test done");
    phase_err_lt_10ns <= 1'h1;
    p = 0;
    await(lock_detect, 1'h1, 700);
    check("lock_delay", p > 380 && lock_detect === 1'h1, 1'h1);
    host.send(fw(1'h0, 5'h18));
    repeat (30) @(posedge ref_clk);
    check("lock_detect", lock_detect, 1'h0);
    phase_err_lt_6ns <= 1'h1;
    await(lock_detect, 1'h1, 700);
    check("lock_detect", lock_detect, 1'h1);
    host.send(fw(1'h1, 5'h08));
    q = sd_n;
    host.send(int_word);
    check("sd_reset_count", sd_n, q);
    $display("lock test done");
    for (int i = 0; i < 5; i++) begin
      host.send(fw(1'h0, ut[i]));
      check("function_bits", fn_bits, et[i]);
      if (i == 2) begin
        host.send({17'h0, 12'h045, 3'h1});
        host.send(int_word);
        check("phase_word", phase_word, 12'h045);
        check("fractional_modulus", fractional_modulus, 12'hABC);
      end
    end
    $display("function test done");
    host.send(fw(1'h0, 5'h08));
    host.send(tw(2'h1, 12'h004));
    check("clock_divider_value", clock_divider_value, 12'h004);
    q = fl_n;
    host.send(int_word);
    repeat (100) @(posedge ref_clk);
    check("fast_lock_span", (fl_n - q) inside {[30:50]}, 1'h1);
    host.send(tw(2'h2, 12'h004));
    q = rs_n;
    host.send(int_word);
    repeat (100) @(posedge ref_clk);
    check("resync_count", rs_n, q + 1);
    host.send(tw(2'h0, 12'h004));
    q = rs_n + fl_n;
    host.send(int_word);
    repeat (100) @(posedge ref_clk);
    check("timeout_idle", rs_n + fl_n, q);
    $display("timeout test done");
    conclude();
  end
endmodule
